// ### hcfr_host_model.sv
`timescale 1ns/10ps
module hcfr_host_model (
	input wire logic clk_i,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	output logic rd_o,
	input wire logic [7:0] rdata_i
);
	initial {addr_o, wr_o, wdata_o, rd_o} = '0;
	// One byte per access; type and ratio go in before any calibration
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk_i);
		{addr_o, wr_o, rd_o, wdata_o} = {a, w, !w, d};
		@(negedge clk_i);
		{wr_o, rd_o, wdata_o} = {2'b00, ~d};
		@(negedge clk_i);
		q = rdata_i;
	endtask
endmodule

// ### hcfr_pkg.sv
package hcfr_pkg;
	// Register byte addresses on the host command bus
	localparam logic [7:0] HCFR_ADDR_COMP = 8'h18;
	localparam logic [7:0] HCFR_ADDR_BEMF = 8'h19;
	localparam logic [7:0] HCFR_ADDR_FBCTL = 8'h1a;
	// Reset values
	localparam logic [7:0] HCFR_RST_COMP = 8'h0d;
	localparam logic [7:0] HCFR_RST_BEMF = 8'h6d;
	localparam logic [7:0] HCFR_RST_FBCTL = 8'h36;
	localparam logic [7:0] HCFR_UNMAPPED_DATA = 8'h00;
	// Feedback control field positions
	localparam int HCFR_FB_TYPE_BIT = 7;
	localparam int HCFR_FB_BRAKE_MSB = 6;
	localparam int HCFR_FB_BRAKE_LSB = 4;
	localparam int HCFR_FB_LOOP_MSB = 3;
	localparam int HCFR_FB_LOOP_LSB = 2;
	localparam int HCFR_FB_AMP_MSB = 1;
	localparam int HCFR_FB_AMP_LSB = 0;
	// Scaling constants
	localparam logic [8:0] HCFR_FULL_SCALE = 9'h0ff;
	localparam logic [31:0] HCFR_BEMF_REF_MV = 32'h0000_04c4;
	localparam logic [31:0] HCFR_FB_GAIN_NUM = 32'h0000_ffff;
	// Back-EMF amplifier gain in hundredths, per code, per actuator type
	localparam logic [9:0] HCFR_ROT_GAIN_X100 [4] = '{10'h021, 10'h064, 10'h0b4, 10'h190};
	localparam logic [9:0] HCFR_LIN_GAIN_X100 [4] = '{10'h0c8, 10'h190, 10'h320, 10'h3e8};
	// Brake-to-drive gain multiplier per code, zero means braking off
	localparam logic [4:0] HCFR_BRAKE_MULT [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
endpackage

// ### hcfr_regs.sv
`timescale 1ns/10ps

// Register map as seen from the host command engine:
//   compensation result, full byte, read/write
//   back-EMF result, full byte, read/write
//   feedback control: type bit, brake ratio, loop gain, amplifier gain
// Any other address reads as zero and swallows writes without effect.
//
// Bus timing:
//   a write strobe lands in its register on the edge that samples it
//   a read strobe latches the read data on the edge that samples it
//   read data then holds until the next read strobe, so a slow host
//   engine may pick it up at leisure
//   a read right after a write returns the freshly written value
//
// Calibration handshake:
//   the calibration engine pulses its done flag for one cycle with the
//   compensation value, the back-EMF value and the amplifier gain code
//   all three are taken together on that edge
//   on the result registers calibration beats a host write of the same
//   cycle, since a finished run must never be silently discarded
//   on the control register a host write beats the gain update, so the
//   host keeps the last word on the operating mode it selected
//
// Derived outputs:
//   every derived value is worked out from the registers and the live
//   inputs in one combinational cloud and registered once
//   the dividers are deep; registering keeps them off the output paths
//   at the cost of one cycle of lag behind any change of cause
//   compensation scales the drive gain only while playback runs, so an
//   idle engine sees the raw gain it was handed
//   the back-EMF level is reported in millivolts, rounded down
//   the drive feedback gain falls as the back-EMF result rises; a zero
//   result would divide by zero, so it saturates to full scale instead
//   the feedback gains read zero whenever the loop is open
//   the brake feedback gain is the drive feedback gain times the
//   multiplier that the ratio code selects; the top code turns braking off
//
// Limitations:
//   the back-EMF result goes stale after any change of rated voltage;
//   only a new calibration run refreshes it
//   the type and ratio fields are best set before calibration starts,
//   since calibration picks its amplifier gain for the selected type
//   the loop gain field is stored and mirrored only; no logic here uses it
//
// Reset:
//   asynchronous, active low; all registers take their documented values
//   and the mirrored field outputs take the fields of the control reset
module hcfr_regs
	import hcfr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_en_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_en_i,
	output logic [7:0] reg_rdata_o,
	input wire logic cal_done_i,
	input wire logic [7:0] cal_comp_value_i,
	input wire logic [7:0] cal_bemf_value_i,
	input wire logic [1:0] cal_amp_gain_i,
	input wire logic playback_active_i,
	input wire logic closed_loop_i,
	input wire logic [7:0] drive_gain_i,
	output logic [8:0] comp_drive_gain_o,
	output logic [15:0] back_emf_mv_o,
	output logic [15:0] drive_feedback_gain_o,
	output logic [19:0] brake_feedback_gain_o,
	output logic actuator_type_o,
	output logic [2:0] brake_gain_ratio_o,
	output logic [1:0] loop_gain_o,
	output logic [1:0] back_emf_amp_gain_o
);
	logic [7:0] comp_reg;
	logic [7:0] bemf_reg;
	logic [7:0] fbctl_reg;
	logic [8:0] comp_drive_next;
	logic [15:0] bemf_mv_next;
	logic [15:0] fb_gain_next;
	logic [19:0] brake_gain_next;

	// Scale a value by (255 + coef) / 255, i.e. by 1 + coef/255
	function automatic logic [8:0] hcfr_comp_scale(input logic [7:0] value, input logic [7:0] coef);
		logic [16:0] prod;
		prod = 17'(value) * 17'({1'b0, coef} + HCFR_FULL_SCALE);
		return 9'(prod / 17'(HCFR_FULL_SCALE));
	endfunction

	// Amplifier gain in hundredths for the selected actuator type
	function automatic logic [9:0] hcfr_amp_gain(input logic linear, input logic [1:0] code);
		return linear ? HCFR_LIN_GAIN_X100[code] : HCFR_ROT_GAIN_X100[code];
	endfunction

	// Host write strobe aimed at one register address
	function automatic logic hcfr_wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] target);
		return wr && (addr == target);
	endfunction

	// Compensation result: calibration completion wins over a same-cycle host write
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			comp_reg <= HCFR_RST_COMP;
		end else if (cal_done_i) begin
			comp_reg <= cal_comp_value_i;
		end else if (hcfr_wr_hit(reg_wr_en_i, reg_addr_i, HCFR_ADDR_COMP)) begin
			comp_reg <= reg_wdata_i;
		end
	end

	// Back-EMF result; stale after a rated voltage change until recalibrated
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bemf_reg <= HCFR_RST_BEMF;
		end else if (cal_done_i) begin
			bemf_reg <= cal_bemf_value_i;
		end else if (hcfr_wr_hit(reg_wr_en_i, reg_addr_i, HCFR_ADDR_BEMF)) begin
			bemf_reg <= reg_wdata_i;
		end
	end

	// Feedback control; calibration also fills in the amplifier gain field
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fbctl_reg <= HCFR_RST_FBCTL;
		end else if (hcfr_wr_hit(reg_wr_en_i, reg_addr_i, HCFR_ADDR_FBCTL)) begin
			fbctl_reg <= reg_wdata_i;
		end else if (cal_done_i) begin
			fbctl_reg[HCFR_FB_AMP_MSB:HCFR_FB_AMP_LSB] <= cal_amp_gain_i;
		end
	end

	// Read port; unmapped addresses return zero
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= HCFR_UNMAPPED_DATA;
		end else if (reg_rd_en_i) begin
			unique case (reg_addr_i)
				HCFR_ADDR_COMP: reg_rdata_o <= comp_reg;
				HCFR_ADDR_BEMF: reg_rdata_o <= bemf_reg;
				HCFR_ADDR_FBCTL: reg_rdata_o <= fbctl_reg;
				default: reg_rdata_o <= HCFR_UNMAPPED_DATA;
			endcase
		end
	end

	// Derived gains; the dividers are deep, so results are registered once
	always_comb begin
		logic [31:0] num;
		logic [31:0] den;
		logic [31:0] fb_raw;
		num = 32'h0;
		den = 32'h0;
		fb_raw = 32'h0;
		// Compensation applies only while playing, raw gain passes otherwise
		comp_drive_next = playback_active_i ? hcfr_comp_scale(drive_gain_i, comp_reg) : 9'(drive_gain_i);
		// mV = value * 1220 * 100 / (255 * gain_x100)
		num = 32'(bemf_reg) * HCFR_BEMF_REF_MV * 32'd100;
		den = 32'(HCFR_FULL_SCALE) * 32'(hcfr_amp_gain(fbctl_reg[HCFR_FB_TYPE_BIT],
			fbctl_reg[HCFR_FB_AMP_MSB:HCFR_FB_AMP_LSB]));
		bemf_mv_next = 16'(num / den);
		// Larger back-EMF needs less loop gain; a zero result saturates
		fb_raw = (bemf_reg == 8'h00) ? HCFR_FB_GAIN_NUM : HCFR_FB_GAIN_NUM / 32'(bemf_reg);
		fb_gain_next = closed_loop_i ? 16'(fb_raw) : 16'h0000;
		brake_gain_next = 20'(fb_gain_next) * 20'(HCFR_BRAKE_MULT[fbctl_reg[HCFR_FB_BRAKE_MSB:HCFR_FB_BRAKE_LSB]]);
	end

	// Output registers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			comp_drive_gain_o <= 9'h000;
			back_emf_mv_o <= 16'h0000;
			drive_feedback_gain_o <= 16'h0000;
			brake_feedback_gain_o <= 20'h00000;
		end else begin
			comp_drive_gain_o <= comp_drive_next;
			back_emf_mv_o <= bemf_mv_next;
			drive_feedback_gain_o <= fb_gain_next;
			brake_feedback_gain_o <= brake_gain_next;
		end
	end

	// Field outputs mirror the control register one cycle later
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			actuator_type_o <= HCFR_RST_FBCTL[HCFR_FB_TYPE_BIT];
			brake_gain_ratio_o <= HCFR_RST_FBCTL[HCFR_FB_BRAKE_MSB:HCFR_FB_BRAKE_LSB];
			loop_gain_o <= HCFR_RST_FBCTL[HCFR_FB_LOOP_MSB:HCFR_FB_LOOP_LSB];
			back_emf_amp_gain_o <= HCFR_RST_FBCTL[HCFR_FB_AMP_MSB:HCFR_FB_AMP_LSB];
		end else begin
			actuator_type_o <= fbctl_reg[HCFR_FB_TYPE_BIT];
			brake_gain_ratio_o <= fbctl_reg[HCFR_FB_BRAKE_MSB:HCFR_FB_BRAKE_LSB];
			loop_gain_o <= fbctl_reg[HCFR_FB_LOOP_MSB:HCFR_FB_LOOP_LSB];
			back_emf_amp_gain_o <= fbctl_reg[HCFR_FB_AMP_MSB:HCFR_FB_AMP_LSB];
		end
	end
endmodule

// ### hcfr_regs_monitor.sv
`timescale 1ns/10ps
module hcfr_regs_monitor
	import hcfr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_en_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic cal_done_i,
	input wire logic [7:0] cal_comp_value_i,
	input wire logic [7:0] cal_bemf_value_i,
	input wire logic playback_active_i,
	input wire logic closed_loop_i,
	input wire logic [7:0] drive_gain_i,
	input wire logic [8:0] comp_drive_gain_o,
	input wire logic [15:0] drive_feedback_gain_o,
	input wire logic [19:0] brake_feedback_gain_o,
	input wire logic actuator_type_o,
	input wire logic [2:0] brake_gain_ratio_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Calibration pulse, then a read of one result two cycles on
	sequence s_cal_rd(a);
		cal_done_i ##2 (reg_rd_en_i && reg_addr_i == a);
	endsequence
	AST_RST_OUT: assert property ($rose(rst_n_i) |-> !actuator_type_o && brake_gain_ratio_o == 3'h3)
		else $error("bad reset fields");
	AST_RD_TYPE: assert property (reg_rd_en_i && reg_addr_i == HCFR_ADDR_FBCTL |=> reg_rdata_o[7] == actuator_type_o)
		else $error("type mismatch");
	AST_RD_RATIO: assert property (reg_rd_en_i && reg_addr_i == HCFR_ADDR_FBCTL |=> reg_rdata_o[6:4] == brake_gain_ratio_o)
		else $error("ratio mismatch");
	AST_CAL_COMP: assert property (s_cal_rd(HCFR_ADDR_COMP) |=> reg_rdata_o == $past(cal_comp_value_i, 3))
		else $error("comp not loaded");
	AST_CAL_BEMF: assert property (s_cal_rd(HCFR_ADDR_BEMF) |=> reg_rdata_o == $past(cal_bemf_value_i, 3))
		else $error("bemf not loaded");
	AST_PASS_DRIVE: assert property (!playback_active_i |=> comp_drive_gain_o == {1'b0, $past(drive_gain_i)})
		else $error("drive scaled outside playback");
	AST_OPEN_LOOP: assert property (!closed_loop_i |=> drive_feedback_gain_o == 16'h0000)
		else $error("feedback gain in open loop");
	AST_BRAKE_MULT: assert property (brake_gain_ratio_o < 3'h3 |->
		brake_feedback_gain_o == {4'h0, drive_feedback_gain_o} * ({17'h0, brake_gain_ratio_o} + 20'h1))
		else $error("brake ratio wrong");
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import hcfr_pkg::*;
	logic clk = 0, rst_n = 0, cal, pb, cl, wr, rd, at;
	logic [7:0] addr, wd, rdata, cv, bv, dg, r, s;
	logic [1:0] ag;
	logic [8:0] cdg;
	logic [15:0] mv, dfg;
	logic [19:0] bfg;
	logic [2:0] br;
	int n_errors = 0, compares = 0;
	initial forever #2.5 clk = ~clk;
	hcfr_regs i_hcfr_regs(.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_en_i(wr), .reg_wdata_i(wd),
		.reg_rd_en_i(rd), .reg_rdata_o(rdata), .cal_done_i(cal), .cal_comp_value_i(cv), .cal_bemf_value_i(bv),
		.cal_amp_gain_i(ag), .playback_active_i(pb), .closed_loop_i(cl), .drive_gain_i(dg), .comp_drive_gain_o(cdg),
		.back_emf_mv_o(mv), .drive_feedback_gain_o(dfg), .brake_feedback_gain_o(bfg), .actuator_type_o(at),
		.brake_gain_ratio_o(br), .loop_gain_o(), .back_emf_amp_gain_o());
	hcfr_host_model i_hcfr_host_model(.clk_i(clk), .addr_o(addr), .wr_o(wr), .wdata_o(wd), .rd_o(rd), .rdata_i(rdata));
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic print_verdict();
		$display("compares=%0d n_errors=%0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, far beyond the hundred or so cycles the tests need
	initial begin
		#50000;
		n_errors++;
		print_verdict();
	end
	initial begin
		s = 8'h07;
		{cal, pb, cl, cv, bv, ag, dg} = '0;
		repeat (8) @(negedge clk);
		rst_n = 1;
		i_hcfr_host_model.xfer(0, HCFR_ADDR_COMP, 0, r); chk(r, 8'h0d);
		i_hcfr_host_model.xfer(0, HCFR_ADDR_BEMF, 0, r); chk(r, 8'h6d);
		i_hcfr_host_model.xfer(0, HCFR_ADDR_FBCTL, 0, r); chk(r[7:4], 4'h3);
		$display("reset test done");
		// Host write then playback scaling, random drive and result
		repeat (4) begin
			s = lfsr(s);
			dg = lfsr(s);
			i_hcfr_host_model.xfer(1, HCFR_ADDR_COMP, s, r);
			i_hcfr_host_model.xfer(0, HCFR_ADDR_COMP, 0, r); chk(r, s);
			pb = 1;
			repeat (3) @(negedge clk);
			chk(cdg, 20'(dg * (20'd255 + s) / 20'd255));
			pb = 0;
		end
		$display("scaling test done");
		// Calibration loads both results; amp code 1 is unity gain for the rotary type
		ag = 2'h1;
		cl = 1;
		i_hcfr_host_model.xfer(1, HCFR_ADDR_FBCTL, 8'h36, r);
		// Repeated runs stand in for recalibration after a rated voltage change
		repeat (3) begin
			s = lfsr(s);
			cv = s;
			bv = lfsr(s);
			@(negedge clk) cal = 1;
			@(negedge clk) cal = 0;
			i_hcfr_host_model.xfer(0, HCFR_ADDR_COMP, 0, r); chk(r, cv);
			i_hcfr_host_model.xfer(0, HCFR_ADDR_BEMF, 0, r); chk(r, bv);
			chk(mv, 20'(bv * 20'd1220 / 20'd255));
			chk(dfg, bv == 0 ? 20'hffff : 20'hffff / bv);
		end
		$display("calibration test done");
		// Every documented type and ratio code, feedback live
		for (int k = 0; k < 8; k++) begin
			i_hcfr_host_model.xfer(1, HCFR_ADDR_FBCTL, {k[0], k[2:0], 4'h6}, r);
			chk(at, k[0]);
			chk(br, k[2:0]);
			chk(bfg, 20'((bv == 8'h00 ? 20'hffff : 20'hffff / bv) * HCFR_BRAKE_MULT[k]));
		end
		$display("feedback control test done");
		print_verdict();
	end
endmodule
bind hcfr_regs hcfr_regs_monitor i_hcfr_regs_monitor(.*);
